// *** rtl/tcc_cfg.svh ***
// register map, field layout and codes of the timer configuration block
// Overview of operation
// [R1] clock field 0000 stops; 0001..0111 divide by 1,2,4,8,64,256,1024
// [R2] clock field top bit set: low bits pick event channel as count clock
// [R3] software selects undivided clock whenever high-resolution extension is on
// [R4] waveform modes: channel enable puts waveform on pin instead of port value
// [R5] capture actions: channel enable gates capture of that channel
// [R6] mode picks TOP source and update point; 010 and 100 reserved
// [R7] wrap flag at TOP, BOTTOM or both depending on waveform mode
// [R8] normal mode makes no waveform; others reach pins only when enabled
// [R9] software sets port pin direction to output to see the waveform
// [R10] while stopped, compare output value bits set each waveform level
// [R11] event action field selects none, capture, up/down, decode, restart...
// [R12] capture actions turn compare registers to capture, error means overflow
// [R13] event delay bit delays selected event input by one clock
// [R14] event source 0000 none, 0001..0111 reserved, 1nnn channel n
// [R15] selected event channel acts only with a non-none event action
// [R16] capture: channel n feeds A, n+1..n+3 modulo eight feed B, C, D
// [R17] width mode 00 normal, 01 clear high byte, 10 split, 11 reserved
// [R18] first level register bits 3:2 enable and prioritise error interrupt
// [R19] first level register bits 1:0 enable and prioritise wrap interrupt
// [R20] second level register: two bits per channel, D high to A low
// [R21] reserved bits read zero and ignore writes; software writes zeros
// [R22] level 00 disables a request; 01,10,11 low, medium, high
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

`define TCC_IDX_CLK       4'h0
`define TCC_IDX_WAVE      4'h1
`define TCC_IDX_CMPOUT    4'h2
`define TCC_IDX_EVENT     4'h3
`define TCC_IDX_WIDTH     4'h4
`define TCC_IDX_ERRWRAP   4'h6
`define TCC_IDX_CHIRQ     4'h7
`define TCC_IDX_STATUS    4'hE

`define TCC_MASK_CLK      8'h0F
`define TCC_MASK_WAVE     8'hF7
`define TCC_MASK_CMPOUT   8'h0F
`define TCC_MASK_EVENT    8'hFF
`define TCC_MASK_WIDTH    8'h03
`define TCC_MASK_ERRWRAP  8'h0F
`define TCC_MASK_CHIRQ    8'hFF
`define TCC_RESET_VALUE   8'h00

`define TCC_CLK_OFF       4'h0
`define TCC_WAVE_MODE_LSB 0
`define TCC_CHEN_LSB      4
`define TCC_EVENT_SOURCE_SEL_LSB     0
`define TCC_EVENT_DELAY_BIT     4
`define TCC_EVENT_ACTION_SEL_LSB     5
`define TCC_WRAPLVL_LSB   0
`define TCC_ERRLVL_LSB    2
`define TCC_PRESC_W       10

`endif

// *** rtl/tcc_pkg.sv ***
// types of the timer configuration block
package tcc_pkg;

   typedef enum logic [2:0] {
      TCC_WAVE_NORMAL = 3'h0,
      TCC_WAVE_FREQ   = 3'h1,
      TCC_WAVE_RSV2   = 3'h2,
      TCC_WAVE_SINGLE = 3'h3,
      TCC_WAVE_RSV4   = 3'h4,
      TCC_WAVE_DS_TOP = 3'h5,
      TCC_WAVE_DS_BTH = 3'h6,
      TCC_WAVE_DS_BOT = 3'h7
   } tcc_wave_type;

   typedef enum logic [2:0] {
      TCC_ACT_NONE    = 3'h0,
      TCC_ACT_INPUT_CAPTURE_ACTION    = 3'h1,
      TCC_ACT_EVENT_UP_DOWN_COUNT  = 3'h2,
      TCC_ACT_QUADRATURE_DECODE    = 3'h3,
      TCC_ACT_RESTART = 3'h4,
      TCC_ACT_FRQCAP  = 3'h5,
      TCC_ACT_PWCAP   = 3'h6,
      TCC_ACT_RSV     = 3'h7
   } tcc_action_type;

   typedef enum logic [1:0] {
      TCC_WIDTH_NORMAL = 2'h0,
      TCC_WIDTH_HBCLR  = 2'h1,
      TCC_WIDTH_SPLIT  = 2'h2,
      TCC_WIDTH_RSV    = 2'h3
   } tcc_width_type;

   typedef struct packed {
      logic [7:0] clk_src;
      logic [7:0] wave;
      logic [7:0] cmp_out;
      logic [7:0] event_ctl;
      logic [7:0] width;
      logic [7:0] err_wrap_lvl;
      logic [7:0] ch_lvl;
      logic [9:0] presc;
      logic [7:0] ev_dly;
      logic       ack;
      logic [7:0] rdata;
      logic       count_tick;
      logic       action_event;
      logic [3:0] capture_event;
      logic [3:0] capture_en;
      logic [3:0] pin_value;
      logic [3:0] pin_override;
      logic       top_from_cca;
      logic       update_at_bottom;
      logic       wrap_at_top;
      logic       wrap_at_bottom;
      logic       dual_slope;
      logic       capture_mode;
      logic       high_byte_clear;
      logic       dual_8bit;
      logic [1:0] err_irq;
      logic [1:0] wrap_irq;
      logic [7:0] ch_irq;
   } tcc_state_type;

endpackage

// *** rtl/tcc_ctrl.sv ***
// timer configuration registers, count clock, event routing, pin override
`timescale 1ns/1ps
`default_nettype none
`include "tcc_cfg.svh"

module tcc_ctrl #(
   parameter int ADR_W = 6
) (
   input  wire logic             core_clk,
   input  wire logic             srst,
   input  wire logic             clk_en,
   input  wire logic [ADR_W-1:0] wb_adr_i,
   input  wire logic [31:0]      wb_dat_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic             wb_we_i,
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   input  wire logic [7:0]       event_ch,
   input  wire logic [3:0]       wave_gen,
   input  wire logic [3:0]       port_out,
   input  wire logic             error_flag,
   input  wire logic             wrap_flag,
   input  wire logic [3:0]       channel_flag,
   output logic                  count_tick,
   output logic                  action_event,
   output logic      [2:0]       event_action_sel,
   output logic      [3:0]       capture_event,
   output logic      [3:0]       capture_en,
   output logic      [3:0]       waveform_output_pin,
   output logic      [3:0]       pin_override,
   output logic                  top_from_cca,
   output logic                  update_at_bottom,
   output logic                  wrap_at_top,
   output logic                  wrap_at_bottom,
   output logic                  dual_slope,
   output logic                  capture_mode,
   output logic                  high_byte_clear,
   output logic                  dual_8bit_mode,
   output logic      [1:0]       error_irq_req,
   output logic      [1:0]       wrap_irq_req,
   output logic      [7:0]       channel_irq_req
);

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // prescaler tap for a divided clock code
   function automatic logic tap_hit(
      input logic [3:0] sel,
      input logic [9:0] cnt
   );
      logic hit;
      hit = 1'b0;
      unique case (sel[2:0])
         3'h1: hit = 1'b1;
         3'h2: hit = (cnt[0] == 1'b1);
         3'h3: hit = (cnt[1:0] == 2'h3);
         3'h4: hit = (cnt[2:0] == 3'h7);
         3'h5: hit = (cnt[5:0] == 6'h3F);
         3'h6: hit = (cnt[7:0] == 8'hFF);
         3'h7: hit = (cnt[9:0] == 10'h3FF);
         3'h0: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // request level gated by its flag; level 00 means disabled
   function automatic logic [1:0] lvl_gate(
      input logic [1:0] lvl,
      input logic       flag
   );
      return flag ? lvl : 2'h0; // [R22]
   endfunction

   // event channel picked from a base index with a wrapping offset
   function automatic logic pick_ch(
      input logic [7:0] ch,
      input logic [2:0] base,
      input logic [2:0] offs
   );
      logic [2:0] idx;
      idx = 3'(base + offs);
      return ch[idx];
   endfunction

   // capture action decode
   function automatic logic is_capture(input logic [2:0] act);
      return (act == tcc_pkg::TCC_ACT_INPUT_CAPTURE_ACTION)
          || (act == tcc_pkg::TCC_ACT_FRQCAP)
          || (act == tcc_pkg::TCC_ACT_PWCAP);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // state

   tcc_pkg::tcc_state_type st;
   tcc_pkg::tcc_state_type next_st;

   logic [3:0] idx;
   logic       req;
   logic       wr;

   assign idx = wb_adr_i[5:2];
   assign req = wb_cyc_i && wb_stb_i && !st.ack;
   assign wr  = req && wb_we_i && wb_sel_i[0];

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic [3:0] clk_sel;
      logic [2:0] wmode;
      logic [2:0] act;
      logic [3:0] ev_sel;
      logic [3:0] ch_en;
      logic [7:0] ev_in;
      logic       ev_valid;
      logic       running;
      logic       wave_on;
      logic       input_capture_action;
      logic [7:0] rd;
      clk_sel  = 4'h0;
      wmode    = 3'h0;
      act      = 3'h0;
      ev_sel   = 4'h0;
      ch_en    = 4'h0;
      ev_in    = 8'h00;
      ev_valid = 1'b0;
      running  = 1'b0;
      wave_on  = 1'b0;
      input_capture_action     = 1'b0;
      rd       = 8'h00;
      next_st  = st;

      // bus write; reserved bits stay zero
      next_st.ack = req;
      if (wr) begin
         unique case (idx)
            `TCC_IDX_CLK:
               next_st.clk_src = wb_dat_i[7:0] & `TCC_MASK_CLK; // [R21]
            `TCC_IDX_WAVE:
               next_st.wave = wb_dat_i[7:0] & `TCC_MASK_WAVE; // [R21]
            `TCC_IDX_CMPOUT:
               next_st.cmp_out = wb_dat_i[7:0] & `TCC_MASK_CMPOUT; // [R21]
            `TCC_IDX_EVENT:
               next_st.event_ctl = wb_dat_i[7:0] & `TCC_MASK_EVENT;
            `TCC_IDX_WIDTH:
               next_st.width = wb_dat_i[7:0] & `TCC_MASK_WIDTH; // [R21]
            `TCC_IDX_ERRWRAP:
               next_st.err_wrap_lvl = wb_dat_i[7:0] & `TCC_MASK_ERRWRAP;
            `TCC_IDX_CHIRQ:
               next_st.ch_lvl = wb_dat_i[7:0] & `TCC_MASK_CHIRQ;
            default: begin
            end
         endcase
      end

      // bus read; unmapped words read zero
      unique case (idx)
         `TCC_IDX_CLK:     rd = st.clk_src;
         `TCC_IDX_WAVE:    rd = st.wave;
         `TCC_IDX_CMPOUT:  rd = st.cmp_out;
         `TCC_IDX_EVENT:   rd = st.event_ctl;
         `TCC_IDX_WIDTH:   rd = st.width;
         `TCC_IDX_ERRWRAP: rd = st.err_wrap_lvl;
         `TCC_IDX_CHIRQ:   rd = st.ch_lvl;
         `TCC_IDX_STATUS:
            rd = {3'h0,
                  st.dual_8bit,
                  st.high_byte_clear,
                  st.capture_mode,
                  st.count_tick,
                  (st.clk_src[3:0] != `TCC_CLK_OFF)};
         default:          rd = 8'h00;
      endcase
      next_st.rdata = req ? rd : 8'h00;

      // field decode from the current registers
      clk_sel = st.clk_src[3:0];
      wmode   = st.wave[`TCC_WAVE_MODE_LSB +: 3];
      ch_en   = st.wave[`TCC_CHEN_LSB +: 4];
      act     = st.event_ctl[`TCC_EVENT_ACTION_SEL_LSB +: 3];
      ev_sel  = st.event_ctl[`TCC_EVENT_SOURCE_SEL_LSB +: 4];
      running = (clk_sel != `TCC_CLK_OFF);
      input_capture_action    = is_capture(act); // [R12]

      // prescaler runs only while a divided clock is selected
      if (running && !clk_sel[3]) begin
         next_st.presc = st.presc + 10'h001;
      end else begin
         next_st.presc = 10'h000;
      end

      // count clock from a prescaler tap or an event channel
      if (clk_sel[3]) begin
         next_st.count_tick = event_ch[clk_sel[2:0]]; // [R2]
      end else begin
         next_st.count_tick = tap_hit(clk_sel, st.presc); // [R1]
      end

      // event input, optionally one clock late
      next_st.ev_dly = event_ch;
      if (st.event_ctl[`TCC_EVENT_DELAY_BIT]) begin
         ev_in = st.ev_dly; // [R13]
      end else begin
         ev_in = event_ch;
      end

      // only 1nnn names a channel
      ev_valid = ev_sel[3]; // [R14]

      // non-capture actions see channel n alone
      next_st.action_event = 1'b0;
      if (ev_valid) begin
         unique case (act)
            tcc_pkg::TCC_ACT_NONE: begin
               next_st.action_event = 1'b0; // [R15]
            end
            tcc_pkg::TCC_ACT_EVENT_UP_DOWN_COUNT,
            tcc_pkg::TCC_ACT_QUADRATURE_DECODE,
            tcc_pkg::TCC_ACT_RESTART: begin
               next_st.action_event = ev_in[ev_sel[2:0]]; // [R11]
            end
            tcc_pkg::TCC_ACT_INPUT_CAPTURE_ACTION,
            tcc_pkg::TCC_ACT_FRQCAP,
            tcc_pkg::TCC_ACT_PWCAP: begin
               // capture actions route per channel below
               next_st.action_event = 1'b0;
            end
            tcc_pkg::TCC_ACT_RSV: begin
               // reserved action does nothing
               next_st.action_event = 1'b0;
            end
         endcase
      end

      // capture routing, channel n to A, wrapping upward to D
      for (int k = 0; k < 4; k++) begin
         next_st.capture_event[k] = ev_valid && input_capture_action && ch_en[k] // [R5]
            && pick_ch(ev_in, ev_sel[2:0], 3'(k)); // [R16]
      end
      next_st.capture_en   = input_capture_action ? ch_en : 4'h0; // [R5]
      next_st.capture_mode = input_capture_action; // [R12]

      // waveform mode decode
      next_st.top_from_cca     = 1'b0;
      next_st.update_at_bottom = 1'b0;
      next_st.wrap_at_top      = 1'b0;
      next_st.wrap_at_bottom   = 1'b0;
      next_st.dual_slope       = 1'b0;
      unique case (wmode)
         tcc_pkg::TCC_WAVE_NORMAL: begin
            next_st.wrap_at_top = 1'b1; // [R6] [R7]
         end
         tcc_pkg::TCC_WAVE_FREQ: begin
            next_st.top_from_cca = 1'b1; // [R6]
            next_st.wrap_at_top  = 1'b1; // [R7]
         end
         tcc_pkg::TCC_WAVE_SINGLE: begin
            next_st.update_at_bottom = 1'b1; // [R6]
            next_st.wrap_at_bottom   = 1'b1; // [R7]
         end
         tcc_pkg::TCC_WAVE_DS_TOP: begin
            next_st.update_at_bottom = 1'b1;
            next_st.wrap_at_top      = 1'b1; // [R7]
            next_st.dual_slope       = 1'b1;
         end
         tcc_pkg::TCC_WAVE_DS_BTH: begin
            next_st.update_at_bottom = 1'b1;
            next_st.wrap_at_top      = 1'b1; // [R7]
            next_st.wrap_at_bottom   = 1'b1; // [R7]
            next_st.dual_slope       = 1'b1;
         end
         tcc_pkg::TCC_WAVE_DS_BOT: begin
            next_st.update_at_bottom = 1'b1;
            next_st.wrap_at_bottom   = 1'b1; // [R7]
            next_st.dual_slope       = 1'b1;
         end
         default: begin
            // reserved codes leave every decode low
         end
      endcase

      // a waveform exists only in frequency or PWM modes
      wave_on = (wmode == tcc_pkg::TCC_WAVE_FREQ)
             || (wmode == tcc_pkg::TCC_WAVE_SINGLE)
             || wmode[2] && (wmode != tcc_pkg::TCC_WAVE_RSV4); // [R8]

      // pin override and level seen on each pin
      for (int k = 0; k < 4; k++) begin
         next_st.pin_override[k] = wave_on && ch_en[k] && !input_capture_action; // [R4]
         if (!next_st.pin_override[k]) begin
            next_st.pin_value[k] = port_out[k];
         end else if (!running) begin
            next_st.pin_value[k] = st.cmp_out[k]; // [R10]
         end else begin
            next_st.pin_value[k] = wave_gen[k]; // [R4] [R8]
         end
      end

      // counter width
      next_st.high_byte_clear = 1'b0;
      next_st.dual_8bit       = 1'b0;
      unique case (st.width[1:0])
         tcc_pkg::TCC_WIDTH_NORMAL: begin
            // plain sixteen-bit count
         end
         tcc_pkg::TCC_WIDTH_HBCLR: begin
            next_st.high_byte_clear = 1'b1; // [R17]
         end
         tcc_pkg::TCC_WIDTH_SPLIT: begin
            next_st.dual_8bit = 1'b1; // [R17]
         end
         tcc_pkg::TCC_WIDTH_RSV: begin
            // reserved code leaves both low
         end
      endcase

      // interrupt requests at their programmed level
      next_st.err_irq = lvl_gate(
         st.err_wrap_lvl[`TCC_ERRLVL_LSB +: 2], error_flag); // [R18]
      next_st.wrap_irq = lvl_gate(
         st.err_wrap_lvl[`TCC_WRAPLVL_LSB +: 2], wrap_flag); // [R19]
      for (int k = 0; k < 4; k++) begin
         next_st.ch_irq[2*k +: 2] =
            lvl_gate(st.ch_lvl[2*k +: 2], channel_flag[k]); // [R20]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge core_clk) begin
      if (srst) begin
         st <= '0;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign wb_dat_o            = {24'h000000, st.rdata};
   assign wb_ack_o            = st.ack;
   assign count_tick          = st.count_tick;
   assign action_event        = st.action_event;
   assign event_action_sel    = st.event_ctl[`TCC_EVENT_ACTION_SEL_LSB +: 3];
   assign capture_event       = st.capture_event;
   assign capture_en          = st.capture_en;
   assign waveform_output_pin = st.pin_value;
   assign pin_override        = st.pin_override;
   assign top_from_cca        = st.top_from_cca;
   assign update_at_bottom    = st.update_at_bottom;
   assign wrap_at_top         = st.wrap_at_top;
   assign wrap_at_bottom      = st.wrap_at_bottom;
   assign dual_slope          = st.dual_slope;
   assign capture_mode        = st.capture_mode;
   assign high_byte_clear     = st.high_byte_clear;
   assign dual_8bit_mode      = st.dual_8bit;
   assign error_irq_req       = st.err_irq;
   assign wrap_irq_req        = st.wrap_irq;
   assign channel_irq_req     = st.ch_irq;

endmodule // tcc_ctrl
`default_nettype wire

// *** testbench/tcc_checker.sv ***
// port checker of the timer configuration block
`timescale 1ns/1ps
`default_nettype none
module tcc_checker (
   input wire logic        core_clk,
   input wire logic        srst,
   input wire logic        clk_en,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        error_flag,
   input wire logic        wrap_flag,
   input wire logic [3:0]  channel_flag,
   input wire logic [3:0]  port_out,
   input wire logic        count_tick,
   input wire logic        action_event,
   input wire logic [3:0]  capture_event,
   input wire logic [3:0]  waveform_output_pin,
   input wire logic [3:0]  pin_override,
   input wire logic        top_from_cca,
   input wire logic        update_at_bottom,
   input wire logic        dual_slope,
   input wire logic        capture_mode,
   input wire logic        high_byte_clear,
   input wire logic        dual_8bit_mode,
   input wire logic [1:0]  error_irq_req,
   input wire logic [1:0]  wrap_irq_req,
   input wire logic [7:0]  channel_irq_req
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   ////////////////////////////////////////
   a_ack_pulse: assert property (clk_en && wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_answer: assert property
      (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
      else $error("request not answered");
   a_dat_upper: assert property (wb_dat_o[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_err_quiet: assert property
      (!error_flag |=> error_irq_req == 2'h0)
      else $error("error request without flag");
   a_wrap_quiet: assert property
      (!wrap_flag |=> wrap_irq_req == 2'h0)
      else $error("wrap request without flag");
   a_chan_quiet: assert property
      (!channel_flag[0] |=> channel_irq_req[1:0] == 2'h0)
      else $error("channel request without flag");
   a_width_excl: assert property
      (!(high_byte_clear && dual_8bit_mode))
      else $error("two width modes at once");
   a_input_capture_action_nopin: assert property
      (capture_mode |-> pin_override == 4'h0)
      else $error("override in capture use");
   a_slope_upd: assert property
      (dual_slope |-> update_at_bottom && !top_from_cca)
      else $error("dual slope decode wrong");
   a_pin_port: assert property
      (clk_en && pin_override == 4'h0 ##1 pin_override == 4'h0
       |-> waveform_output_pin == $past(port_out))
      else $error("pin not port value");
   c_tick: cover property (count_tick);
   c_action: cover property (action_event);
   c_capture: cover property (capture_event != 4'h0);
endmodule // tcc_checker
`default_nettype wire

// *** testbench/tcc_partner.sv ***
// event channels and waveform generator seen by the block
`timescale 1ns/1ps
`default_nettype none
module tcc_partner (
   input  wire logic       core_clk,
   input  wire logic [7:0] fire,
   output logic      [7:0] event_ch = 8'h00,
   output logic      [3:0] wave_gen = 4'h5
);
   // one-cycle event pulses; waveform levels change every cycle
   always @(posedge core_clk) begin
      event_ch <= fire;
      wave_gen <= ~wave_gen;
   end
endmodule // tcc_partner
`default_nettype wire

// *** testbench/tcc_ctrl_test.sv ***
// self-checking bench of the timer configuration block
`timescale 1ns/1ps
`default_nettype none
module tcc_ctrl_test;
   logic        core_clk = 1'b0;
   logic        srst     = 1'b1;
   logic        clk_en   = 1'b1;
   logic [5:0]  adr      = 6'h00;
   logic [31:0] dat      = 32'h0;
   logic [3:0]  sel      = 4'h0;
   logic        we       = 1'b0;
   logic [1:0]  cs       = 2'h0;
   logic [7:0]  fire     = 8'h00;
   logic [3:0]  pout     = 4'h0;
   logic        ef       = 1'b0;
   logic        wf       = 1'b0;
   logic [3:0]  cf       = 4'h0;
   logic [31:0] rdat;
   logic [7:0]  evch, cirq;
   logic [3:0]  wg, cev, cen, pin, ovr;
   logic [2:0]  asel;
   logic [1:0]  eirq, wirq;
   logic        ack, tick, aev, tcca, ubot, wtop, wbot, dsl, cmode, hbc, spl;
   int          seed = 32'hF06B948B;
   int          err_count = 0;
   int          compares = 0;
   logic [7:0]  msk [8] = '{8'h0F, 8'hF7, 8'h0F, 8'hFF, 8'h03, 8'h00,
                           8'h0F, 8'hFF};
   int          dv [8] = '{0, 1, 2, 4, 8, 64, 256, 1024};

   always #25 core_clk = ~core_clk;

   tcc_ctrl tcc_ctrl_inst (
      .core_clk(core_clk), .srst(srst), .clk_en(clk_en), .wb_adr_i(adr),
      .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cs[1]),
      .wb_stb_i(cs[0]), .wb_dat_o(rdat), .wb_ack_o(ack), .event_ch(evch),
      .wave_gen(wg), .port_out(pout), .error_flag(ef), .wrap_flag(wf),
      .channel_flag(cf), .count_tick(tick), .action_event(aev),
      .event_action_sel(asel), .capture_event(cev), .capture_en(cen),
      .waveform_output_pin(pin), .pin_override(ovr), .top_from_cca(tcca),
      .update_at_bottom(ubot), .wrap_at_top(wtop), .wrap_at_bottom(wbot),
      .dual_slope(dsl), .capture_mode(cmode), .high_byte_clear(hbc),
      .dual_8bit_mode(spl), .error_irq_req(eirq), .wrap_irq_req(wirq),
      .channel_irq_req(cirq));
   tcc_partner tcc_partner_inst (
      .core_clk(core_clk), .fire(fire), .event_ch(evch), .wave_gen(wg));
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic results;
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic wb(input logic [3:0] i, input logic w,
                     input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      adr <= {i, 2'b00};
      we <= w;
      dat <= {24'h0, d};
      sel <= 4'h1;
      cs <= 2'h3;
      do begin
         @(posedge core_clk);
         n++;
      end while (ack !== 1'b1 && n < 16);
      if (ack !== 1'b1) begin
         err_count++;
         results();
      end
      q = rdat[7:0];
      cs <= 2'h0;
      we <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wr(input logic [3:0] i, input logic [7:0] d);
      logic [7:0] q;
      wb(i, 1'b1, d, q);
   endtask

   // pulses the mask four times, counting what the block reports
   task automatic run(input logic [7:0] m, output int t, output int a,
                      output int f, output logic [3:0] c);
      t = 0;
      a = 0;
      f = -1;
      c = 4'h0;
      for (int i = 0; i < 40; i++) begin
         fire <= (i % 8 == 0 && i < 32) ? m : 8'h00;
         @(posedge core_clk);
         t += tick;
         a += aev;
         c |= cev;
         if (aev === 1'b1 && f < 0) f = i;
      end
   endtask

   function automatic logic [5:0] mdec(input int m);
      case (m)
         0: return 6'b000100;
         1: return 6'b110100;
         3: return 6'b101010;
         5: return 6'b101101;
         6: return 6'b101111;
         7: return 6'b101011;
         default: return 6'b000000;
      endcase
   endfunction
   ////////////////////////////////////////
   initial begin : main
      logic [7:0] r, q;
      logic [3:0] c;
      logic [2:0] n;
      int t, a, f0, f1, e;
      logic cap;
      repeat (20) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      for (int k = 0; k < 8; k++) begin
         r = $random(seed);
         wb(k[3:0], 1'b0, 8'h00, q);
         chk(q, 8'h00);
         wr(k[3:0], r);
         wb(k[3:0], 1'b0, 8'h00, q);
         chk(q, r & msk[k]);
      end
      for (int k = 0; k < 8; k++) wr(k[3:0], 8'h00);
      $display("registers done");
      for (int k = 0; k < 8; k++) begin
         wr(4'h0, k[7:0]);
         t = 0;
         repeat (2048) begin
            @(posedge core_clk);
            t += tick;
         end
         e = k ? 2048 / dv[k] : 0;
         chk((t >= e - 1 && t <= e + 1) ? e : t, e);
      end
      n = $random(seed);
      wr(4'h0, {5'h01, n});
      run(8'h01 << n, t, a, f0, c);
      chk(t, 4);
      run(8'h01 << 3'(n + 3'h1), t, a, f0, c);
      chk(t, 0);
      $display("count clock done");
      wr(4'h1, 8'hF1);
      for (int k = 0; k < 8; k++) begin
         cap = (k == 1 || k == 5 || k == 6);
         wr(4'h3, {k[2:0], 2'b01, n});
         run(8'h01 << n | 8'h01 << 3'(n + 3'h2), t, a, f0, c);
         chk(asel, k[2:0]);
         chk(a, (k >= 2 && k <= 4) ? 4 : 0);
         chk(c, cap ? 4'h5 : 4'h0);
         chk(cmode, cap);
         chk(ovr, cap ? 4'h0 : 4'hF);
         chk(cen, cap ? 4'hF : 4'h0);
      end
      wr(4'h3, {5'h09, n});
      run(8'h01 << n, t, a, f0, c);
      wr(4'h3, {5'h0B, n});
      run(8'h01 << n, t, a, f1, c);
      chk(f1 - f0, 1);
      chk(a, 4);
      wr(4'h3, 8'h20);
      run(8'hFF, t, a, f0, c);
      chk(c, 4'h0);
      wr(4'h3, 8'h85);
      run(8'hFF, t, a, f0, c);
      chk(a, 0);
      $display("events done");
      wr(4'h3, 8'h00);
      wr(4'h0, 8'h01);
      for (int k = 0; k < 8; k++) begin
         wr(4'h1, {5'h14, k[2:0]});
         chk({|ovr, tcca, ubot, wtop, wbot, dsl}, mdec(k));
      end
      wb(4'hE, 1'b0, 8'h00, q);
      chk(q, 8'h03);
      wr(4'h1, 8'hA1);
      pout <= $random(seed);
      repeat (3) @(posedge core_clk);
      chk(pin, (4'hA & ~wg) | (4'h5 & pout));
      r = $random(seed);
      wr(4'h2, r);
      wr(4'h0, 8'h00);
      repeat (2) @(posedge core_clk);
      chk(pin, (4'hA & r[3:0]) | (4'h5 & pout));
      wr(4'h1, 8'hA0);
      repeat (2) @(posedge core_clk);
      chk(pin, pout);
      clk_en <= 1'b0;
      pout <= ~pout;
      repeat (3) @(posedge core_clk);
      chk(pin, 4'(~pout));
      clk_en <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk(pin, pout);
      $display("waveform done");
      for (int k = 0; k < 4; k++) begin
         wr(4'h4, k[7:0]);
         chk({hbc, spl}, k == 1 ? 2'h2 : k == 2 ? 2'h1 : 2'h0);
      end
      r = $random(seed);
      q = $random(seed);
      c = $random(seed);
      wr(4'h6, r);
      wr(4'h7, q);
      ef <= 1'b1;
      wf <= 1'b1;
      cf <= c;
      repeat (2) @(posedge core_clk);
      chk(eirq, r[3:2]);
      chk(wirq, r[1:0]);
      chk(cirq, q & {{2{c[3]}}, {2{c[2]}}, {2{c[1]}}, {2{c[0]}}});
      ef <= 1'b0;
      wf <= 1'b0;
      cf <= 4'h0;
      repeat (2) @(posedge core_clk);
      chk({eirq, wirq, cirq}, 12'h000);
      $display("interrupt levels done");
      results();
   end
endmodule // tcc_ctrl_test

bind tcc_ctrl tcc_checker tcc_checker_inst (
   .core_clk, .srst, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
   .error_flag, .wrap_flag, .channel_flag, .port_out, .count_tick,
   .action_event, .capture_event, .waveform_output_pin, .pin_override,
   .top_from_cca, .update_at_bottom, .dual_slope, .capture_mode,
   .high_byte_clear, .dual_8bit_mode, .error_irq_req, .wrap_irq_req,
   .channel_irq_req);
`default_nettype wire
